// ==== inc/sdil_defines.svh ====
// Constants for the serial converter input latch
`ifndef SDIL_DEFINES_SVH
`define SDIL_DEFINES_SVH
`define SDIL_WORD_BITS 12
`define SDIL_HOLD_RESET 12'h000
`define SDIL_SHIFT_RESET 12'h000
`define SDIL_BUF_DEPTH 2
`endif

// ==== inc/sdil_pkg.sv ====
// Types for the serial converter input latch
`include "sdil_defines.svh"
package sdil_pkg;
  // One converter word
  typedef logic [`SDIL_WORD_BITS-1:0] sdil_word_t;
  // Word with its valid flag
  typedef struct packed {
    logic       valid;
    sdil_word_t word;
  } sdil_beat_s;
endpackage : sdil_pkg

// ==== hdl/sdil_latch.sv ====
// Serial-in shift register and load-strobe holding register with core-side buffer
`timescale 1ns/100ps
`include "sdil_defines.svh"
module sdil_latch #(
  parameter int WORD_BITS = `SDIL_WORD_BITS
) (
  // Core clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_rst,
  // Link pins from the host
  input  wire logic                 i_link_clk,
  input  wire logic                 i_serial_data_in,
  input  wire logic                 i_load_strobe_n,
  // Converter switch controls (link domain)
  output logic [WORD_BITS-1:0]      o_switch_code,
  // Latched word stream in the core domain
  output logic                      o_word_valid,
  input  wire logic                 i_word_ready,
  output logic [WORD_BITS-1:0]      o_word_data,
  output logic                      o_word_dropped
);

  // Width of the known-bit counter, enough to count a full word
  localparam int FILL_BITS = $clog2(WORD_BITS + 1);
  // Entries in the core-side buffer
  localparam int BUF_DEPTH = `SDIL_BUF_DEPTH;

  // Shift register, link domain, no reset
  logic [WORD_BITS-1:0] shift_q;
  // Holding register, latched on strobe rise
  logic [WORD_BITS-1:0] hold_q;
  // Strobe seen on link clock for edge tracking
  logic                 strobe_ln_q;
  // Toggle marking each completed load
  logic                 load_tgl_q;
  // Shifts since reset, saturating at one full word
  logic [FILL_BITS-1:0] fill_q;
  // Latch has opened on a full word since reset
  logic                 hold_known_q;
  // Shift register holds only known bits
  wire                  shift_full  = (fill_q == FILL_BITS'(WORD_BITS));
  // Strobe rising edge as seen by the link clock
  wire                  strobe_rise = !strobe_ln_q && i_load_strobe_n;

  // Shift on rising link clock while strobe high
  always_ff @(posedge i_link_clk) begin
    if (i_load_strobe_n) begin
      shift_q <= {shift_q[WORD_BITS-2:0], i_serial_data_in};
    end
  end

  // Holding register: level latch, transparent while strobe low
  // Kept as a true latch: the switches must follow the shift register
  // for the whole time the strobe is low, not only at link clock edges
  always_latch begin
    if (!i_load_strobe_n) begin
      hold_q = shift_q;
    end
  end

  // Converter sees latch contents; closes on strobe rise
  assign o_switch_code = hold_q;

  // Load event: toggle on strobe rising edge seen by the link clock
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      strobe_ln_q <= 1'b1;
      load_tgl_q  <= 1'b0;
    end else begin
      strobe_ln_q <= i_load_strobe_n;
      if (strobe_rise) begin
        load_tgl_q <= ~load_tgl_q;
      end
    end
  end

  // Known-bit tracking for the checks below; the data path never reads it,
  // because the shift and holding registers carry no reset and stay unknown
  // until a whole word has been shifted in and the latch has opened once
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      fill_q       <= '0;
      hold_known_q <= 1'b0;
    end else begin
      // One more known bit per shift, stop at a full word
      if (i_load_strobe_n && !shift_full) begin
        fill_q <= fill_q + FILL_BITS'(1);
      end
      // Latch opened while every shifted bit was known
      if (!i_load_strobe_n && shift_full) begin
        hold_known_q <= 1'b1;
      end
    end
  end

  // Held copy of the word for the crossing, stable until next load
  // The word is captured at the link edge that flips the toggle and stays
  // put until the next load, many link clocks later, so the core reads it
  // only after the toggle has passed both synchroniser stages
  logic [WORD_BITS-1:0] xfer_word_q;
  always_ff @(posedge i_link_clk) begin
    if (strobe_rise) begin
      xfer_word_q <= shift_q;
    end
  end

  // Toggle synchroniser into core domain
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic tgl_s3_q;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= load_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  // New word arrives in core domain
  wire load_evt = tgl_s2_q ^ tgl_s3_q;

  // Two-entry buffer storage
  // A load that finds both entries taken is dropped and flagged for one
  // cycle; the entries already held are never overwritten
  sdil_pkg::sdil_beat_s buf_q [2];
  logic                 wr_ptr_q;
  logic                 rd_ptr_q;
  logic [1:0]           count_q;
  logic                 dropped_q;

  // Buffer handshake decode
  wire buf_full  = (count_q == 2'(BUF_DEPTH));
  wire buf_empty = (count_q == 2'h0);
  wire push      = load_evt && !buf_full;
  wire pop       = !buf_empty && i_word_ready;

  // Buffer pointers, count and overflow flag
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_q  <= 1'b0;
      rd_ptr_q  <= 1'b0;
      count_q   <= 2'h0;
      dropped_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q   <= count_q + {1'b0, push} - {1'b0, pop};
      dropped_q <= load_evt && buf_full;
    end
  end

  // Buffer entry write
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (push) begin
      buf_q[wr_ptr_q] <= '{valid: 1'b1, word: xfer_word_q};
    end
  end

  // Output side of the buffer
  assign o_word_valid   = !buf_empty;
  assign o_word_data    = buf_q[rd_ptr_q].word;
  assign o_word_dropped = dropped_q;

  // Holding register matches shift register while strobe low
  chk_hold_follows: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (shift_full && !i_load_strobe_n) |-> ##0 (o_switch_code == shift_q))
    else $error("holding register not transparent while strobe low");

  // Shift register steady while strobe low
  chk_no_shift_low: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (shift_full && !$past(i_load_strobe_n)) |-> $stable(shift_q))
    else $error("shift register moved while strobe low");

  // Shift advances by one bit while strobe high
  chk_shift_step: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (shift_full && $past(i_load_strobe_n)) |->
      shift_q[WORD_BITS-1:1] == $past(shift_q[WORD_BITS-2:0]))
    else $error("shift register did not advance by one");

  // Newest bit enters at the bottom
  chk_lsb_sample: assert property (@(posedge i_link_clk) disable iff (i_rst)
    $past(i_load_strobe_n) |-> shift_q[0] == $past(i_serial_data_in))
    else $error("serial bit not sampled into bottom");

  // Holding steady while strobe high
  chk_hold_kept: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (hold_known_q && i_load_strobe_n && $past(i_load_strobe_n)) |-> $stable(o_switch_code))
    else $error("holding register changed while strobe high");

  // Buffer never exceeds two entries
  chk_buf_bound: assert property (@(posedge i_clock) disable iff (i_rst)
    count_q <= 2'(BUF_DEPTH))
    else $error("buffer count beyond depth");

  // Stalled valid word stays presented
  chk_stall_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_word_valid && !i_word_ready) |=> (o_word_valid && $stable(o_word_data)))
    else $error("stalled word changed");

  // Load event pushes within one cycle unless full
  chk_push_seen: assert property (@(posedge i_clock) disable iff (i_rst)
    (load_evt && !buf_full) |=> o_word_valid)
    else $error("loaded word missing from buffer");

  // Every strobe rise seen by the link clock flips the toggle
  chk_toggle_flip: assert property (@(posedge i_link_clk) disable iff (i_rst)
    strobe_rise |=>
      (load_tgl_q != $past(load_tgl_q)))
    else $error("load toggle did not flip on strobe rise");

  // Toggle holds when no strobe rise is seen
  chk_toggle_quiet: assert property (@(posedge i_link_clk) disable iff (i_rst)
    !strobe_rise |=>
      (load_tgl_q == $past(load_tgl_q)))
    else $error("load toggle flipped without strobe rise");

  // Crossing word is the shift contents at the strobe rise
  chk_xfer_capture: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (hold_known_q && strobe_rise) |=>
      (xfer_word_q == $past(shift_q)))
    else $error("crossing word not captured at strobe rise");

  // Latched code equals the shift contents at the strobe rise
  chk_hold_at_rise: assert property (@(posedge i_link_clk) disable iff (i_rst)
    (hold_known_q && strobe_rise) |->
      (o_switch_code == shift_q))
    else $error("holding register missed word at strobe rise");

  // Load into a full buffer raises the drop flag
  chk_drop_flag: assert property (@(posedge i_clock) disable iff (i_rst)
    (load_evt && buf_full) |=>
      o_word_dropped)
    else $error("lost word not flagged");

  // Drop flag stays low otherwise
  chk_drop_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
    !(load_evt && buf_full) |=>
      !o_word_dropped)
    else $error("drop flag raised without lost word");

  // Dropped load leaves both held words in place
  chk_drop_keep: assert property (@(posedge i_clock) disable iff (i_rst)
    (load_evt && buf_full && !i_word_ready) |=>
      (count_q == 2'h2))
    else $error("held words disturbed by dropped load");

  // Push without pop adds one entry
  chk_count_up: assert property (@(posedge i_clock) disable iff (i_rst)
    (push && !pop) |=>
      (count_q == $past(count_q) + 2'h1))
    else $error("buffer count did not rise on push");

  // Pop without push removes one entry
  chk_count_down: assert property (@(posedge i_clock) disable iff (i_rst)
    (pop && !push) |=>
      (count_q == $past(count_q) - 2'h1))
    else $error("buffer count did not fall on pop");

  // Word pushed into an empty buffer is presented next cycle
  chk_first_word: assert property (@(posedge i_clock) disable iff (i_rst)
    (push && buf_empty) |=>
      (o_word_data == $past(xfer_word_q)))
    else $error("pushed word not presented");

  // Read pointer moves on every pop
  chk_pop_step: assert property (@(posedge i_clock) disable iff (i_rst)
    pop |=>
      (rd_ptr_q != $past(rd_ptr_q)))
    else $error("read pointer stuck on pop");

  // Write pointer moves on every push
  chk_push_step: assert property (@(posedge i_clock) disable iff (i_rst)
    push |=>
      (wr_ptr_q != $past(wr_ptr_q)))
    else $error("write pointer stuck on push");

  // Empty buffer with no load stays invalid
  chk_idle_empty: assert property (@(posedge i_clock) disable iff (i_rst)
    (buf_empty && !load_evt) |=>
      !o_word_valid)
    else $error("valid raised with nothing loaded");

endmodule : sdil_latch

// ==== testbench/sdil_host.sv ====
// Host model that shifts words into the latch and strobes the load line
`timescale 1ns/100ps
module sdil_host (
  // Link pins toward the latch
  output logic o_link_clk,
  output logic o_sdata,
  output logic o_load_n
);
  // Link idle: clock still, strobe high
  initial begin
    o_link_clk = 1'b0;
    o_sdata    = 1'b0;
    o_load_n   = 1'b1;
  end
  // One link clock pulse of 64 ns
  task automatic pulse();
    #32 o_link_clk = 1'b1;
    #32 o_link_clk = 1'b0;
  endtask : pulse
  // Shift n bits MSB first, strobe, close strobe before a link edge
  task automatic send(input logic [23:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      o_sdata = w[i];
      pulse();
    end
    o_sdata  = ~o_sdata; // Released line no longer shows last bit
    o_load_n = 1'b0;
    pulse();
    o_load_n = 1'b1;
    pulse();
  endtask : send
endmodule : sdil_host

// ==== testbench/sdil_latch_tb.sv ====
// Bench for the serial converter input latch
`timescale 1ns/100ps
module sdil_latch_tb;
  logic        i_clock, i_rst, i_word_ready, link_clk, sdata, load_n;
  logic        word_valid, word_dropped;
  logic [11:0] switch_code, word_data;
  logic [11:0] exp_q[$]; // Expected words, oldest first
  logic [31:0] lfsr = 32'h8725A462;
  int          num_errors = 0, samples_checked = 0, cycles = 0, drops = 0;
  sdil_latch u_sdil_latch (.i_clock(i_clock), .i_rst(i_rst), .i_link_clk(link_clk),
    .i_serial_data_in(sdata), .i_load_strobe_n(load_n), .o_switch_code(switch_code),
    .o_word_valid(word_valid), .i_word_ready(i_word_ready), .o_word_data(word_data),
    .o_word_dropped(word_dropped));
  sdil_host u_sdil_host (.o_link_clk(link_clk), .o_sdata(sdata), .o_load_n(load_n));
  // Core clock, 40 ns
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // Compare and count
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic results();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // Random source
  function automatic logic [31:0] next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next
  // Send one word, note it, check the held code
  task automatic send_one(input logic [23:0] w, input int n, input bit keep);
    if (keep) exp_q.push_back(w[11:0]);
    u_sdil_host.send(w, n);
    check(switch_code, w[11:0]);
  endtask : send_one
  // Monitor: oldest note against each accepted word, drop count, timeout
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (word_dropped === 1'b1) drops <= drops + 1;
    if (word_valid === 1'b1 && i_word_ready === 1'b1)
      check(word_data, exp_q.size() ? exp_q.pop_front() : 12'hXXX);
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  // Main sequence
  initial begin
    i_rst        = 1'b1;
    i_word_ready = 1'b0;
    u_sdil_host.pulse();
    u_sdil_host.pulse();
    repeat (5) @(posedge i_clock);
    @(negedge i_clock) i_rst = 1'b0;
    // Random words, some with extra leading bits
    for (int k = 0; k < 6; k++) begin
      lfsr = next(lfsr);
      @(negedge i_clock) i_word_ready = lfsr[31] | lfsr[30];
      send_one(lfsr[23:0], 12 + k % 3, 1'b1);
      @(negedge i_clock) i_word_ready = 1'b1;
      repeat (6) @(posedge i_clock);
    end
    // Consumer stalls: two words held, third lost
    @(negedge i_clock) i_word_ready = 1'b0;
    send_one(24'h000FFF, 12, 1'b1);
    send_one(24'h000801, 12, 1'b1);
    send_one(24'h000A5C, 12, 1'b0);
    repeat (8) @(posedge i_clock);
    check(drops[11:0], 12'h001);
    @(negedge i_clock) i_word_ready = 1'b1;
    repeat (8) @(posedge i_clock);
    check(12'(exp_q.size()), 12'h000);
    results();
  end
endmodule : sdil_latch_tb
